// >>> core/pmc_pkg.sv
// Purpose: shared constants for the power management capability registers
// Assumes: 32-bit configuration access, dword aligned, byte enables per lane
// Notes:   offsets are configuration space byte offsets
`default_nettype none

package pmc_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0]  PMC_CAP_OFS        = 8'h52;  // power_capabilities
    localparam logic [7:0]  PMC_CSR_OFS        = 8'h54;  // power_control_status
    localparam int          PMC_REG_W          = 16;

    // ************************************************************
    // power_capabilities fields
    // ************************************************************
    localparam int          PMC_CAP_WAKE_LSB   = 11;     // wake_state_mask 15:11
    localparam logic [4:0]  PMC_CAP_WAKE_VAL   = 5'h00;
    localparam int          PMC_CAP_DEEP_BIT   = 10;     // deep_doze_capable
    localparam logic        PMC_CAP_DEEP_VAL   = 1'b1;
    localparam int          PMC_CAP_LIGHT_BIT  = 9;      // light_doze_capable
    localparam logic        PMC_CAP_LIGHT_VAL  = 1'b1;
    localparam int          PMC_CAP_AUX_LSB    = 6;      // aux current 8:6
    localparam logic [2:0]  PMC_CAP_AUX_VAL    = 3'h0;
    localparam int          PMC_CAP_INIT_BIT   = 5;      // special init needed
    localparam logic        PMC_CAP_INIT_VAL   = 1'b0;
    localparam int          PMC_CAP_CLK_BIT    = 3;      // wake_needs_bus_clock
    localparam logic        PMC_CAP_CLK_VAL    = 1'b0;
    localparam int          PMC_CAP_REV_LSB    = 0;      // power_spec_revision 2:0
    localparam logic [2:0]  PMC_CAP_REV_OLD    = 3'h2;
    localparam logic [2:0]  PMC_CAP_REV_NEW    = 3'h3;
    localparam logic [15:0] PMC_CAP_RESET      = 16'h0602;

    // ************************************************************
    // power_control_status fields
    // ************************************************************
    localparam int          PMC_CSR_FLAG_BIT   = 15;     // wake_event_flag
    localparam logic        PMC_CSR_FLAG_VAL   = 1'b0;
    localparam int          PMC_CSR_SCALE_LSB  = 13;     // scale 14:13
    localparam logic [1:0]  PMC_CSR_SCALE_VAL  = 2'h0;
    localparam int          PMC_CSR_SEL_LSB    = 9;      // select 12:9
    localparam logic [3:0]  PMC_CSR_SEL_VAL    = 4'h0;
    localparam int          PMC_CSR_SCR_BIT    = 8;      // wake_scratch_bit
    localparam logic        PMC_CSR_SCR_RESET  = 1'b0;
    localparam int          PMC_CSR_RSV_LSB    = 4;      // reserved 7:4
    localparam logic [3:0]  PMC_CSR_RSV_VAL    = 4'h0;
    localparam int          PMC_CSR_NSR_BIT    = 3;      // no soft reset flag
    localparam int          PMC_CSR_STATE_LSB  = 0;      // current_power_state
    localparam logic [15:0] PMC_CSR_RESET      = 16'h0000;

    // ************************************************************
    // power state encodings
    // ************************************************************
    typedef enum logic [1:0] {
        PMC_D0    = 2'h0,
        PMC_D1    = 2'h1,
        PMC_D2    = 2'h2,
        PMC_D3HOT = 2'h3
    } pmc_pstate_e;

    localparam pmc_pstate_e PMC_STATE_RESET    = PMC_D0;

endpackage

`default_nettype wire

// >>> core/pmc_state_hold.sv
// Purpose: holds the writable bits of power_control_status
// Assumes: write strobe already decoded for the control/status halfword
// Notes:   a state change raises a one-cycle pulse, nothing else
`timescale 1ns/1ps
`default_nettype none

module pmc_state_hold
    import pmc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // write side
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_be,
    input  wire logic [15:0] wr_data,
    // held state
    output var  pmc_pstate_e state_r,
    output logic             scratch_r,
    output logic             change_r
);

    // ************************************************************
    // next value logic
    // ************************************************************
    pmc_pstate_e state_nxt;
    logic        scratch_nxt;
    logic        change_nxt;

    // low byte carries the state, high byte the scratch bit
    always_comb begin
        state_nxt   = state_r;
        scratch_nxt = scratch_r;
        change_nxt  = 1'b0;
        if (wr_en && wr_be[0]) begin
            state_nxt  = pmc_pstate_e'(wr_data[PMC_CSR_STATE_LSB +: 2]);
            change_nxt = (state_nxt != state_r);
        end
        if (wr_en && wr_be[1]) begin
            scratch_nxt = wr_data[PMC_CSR_SCR_BIT];
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // leaving D3hot for D0 only updates the field; no reset is made
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r   <= PMC_STATE_RESET;
            scratch_r <= PMC_CSR_SCR_RESET;
            change_r  <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            scratch_r <= scratch_nxt;
            change_r  <= change_nxt;
        end
    end

endmodule

`default_nettype wire

// >>> core/pmc_regs.sv
// Purpose: power management capability and control/status registers
// Assumes: dword configuration access on the configuration clock, at most one read
//          and one write per cycle, revision_select_bit comes from logic on this clock
// Notes:   bytes 50h, 51h, 56h and 57h of the two dwords read as zero here;
//          their owners merge them in outside this block
`timescale 1ns/1ps
`default_nettype none

module pmc_regs
    import pmc_pkg::*;
#(
    parameter int CFG_AW = 8
)
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    // configuration access
    input  wire logic              cfg_rd_req,
    input  wire logic              cfg_wr_req,
    input  wire logic [CFG_AW-1:0] cfg_addr,
    input  wire logic [3:0]        cfg_be,
    input  wire logic [31:0]       cfg_wdata,
    output logic [31:0]            cfg_rdata,
    output logic                   cfg_rdone,
    output logic                   cfg_wdone,
    // revision control from the general control register
    input  wire logic              revision_select_bit,
    // power state towards the rest of the bridge
    output logic [1:0]             current_power_state,
    output logic                   power_state_change,
    output logic                   in_d3hot
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // the map needs at least byte address 57h
    if (CFG_AW < 7) begin : g_bad_aw
        $error("pmc_regs: CFG_AW must be at least 7");
    end

    // ************************************************************
    // helper functions
    // ************************************************************
    // dword index of a configuration byte offset
    function automatic logic [CFG_AW-3:0] dw_index(input logic [7:0] ofs);
        logic [CFG_AW-1:0] wide;
        wide     = CFG_AW'(ofs);
        dw_index = wide[CFG_AW-1:2];
    endfunction

    // fixed and derived capability word
    function automatic logic [15:0] cap_word(input logic rev_sel);
        logic [15:0] w;
        w                                = 16'h0000;
        w[PMC_CAP_WAKE_LSB +: 5]         = PMC_CAP_WAKE_VAL;
        w[PMC_CAP_DEEP_BIT]              = PMC_CAP_DEEP_VAL;
        w[PMC_CAP_LIGHT_BIT]             = PMC_CAP_LIGHT_VAL;
        w[PMC_CAP_AUX_LSB +: 3]          = PMC_CAP_AUX_VAL;
        w[PMC_CAP_INIT_BIT]              = PMC_CAP_INIT_VAL;
        w[PMC_CAP_CLK_BIT]               = PMC_CAP_CLK_VAL;
        // revision follows the select bit
        w[PMC_CAP_REV_LSB +: 3]          = rev_sel ? PMC_CAP_REV_NEW : PMC_CAP_REV_OLD;
        cap_word                         = w;
    endfunction

    // control/status word from held bits and the select bit
    function automatic logic [15:0] csr_word(input logic       rev_sel,
                                             input logic       scratch,
                                             input logic [1:0] pstate);
        logic [15:0] w;
        w                                = 16'h0000;
        w[PMC_CSR_FLAG_BIT]              = PMC_CSR_FLAG_VAL;
        w[PMC_CSR_SCALE_LSB +: 2]        = PMC_CSR_SCALE_VAL;
        w[PMC_CSR_SEL_LSB +: 4]          = PMC_CSR_SEL_VAL;
        w[PMC_CSR_SCR_BIT]               = scratch;
        w[PMC_CSR_RSV_LSB +: 4]          = PMC_CSR_RSV_VAL;
        w[PMC_CSR_NSR_BIT]               = rev_sel;
        w[PMC_CSR_STATE_LSB +: 2]        = pstate;
        csr_word                         = w;
    endfunction

    // ************************************************************
    // address decode
    // ************************************************************
    logic              hit_cap;
    logic              hit_csr;
    logic [1:0]        csr_be;
    logic              csr_wr_en;

    // capability sits in the upper half of its dword, control/status low
    always_comb begin
        hit_cap   = (cfg_addr[CFG_AW-1:2] == dw_index(PMC_CAP_OFS));
        hit_csr   = (cfg_addr[CFG_AW-1:2] == dw_index(PMC_CSR_OFS));
        csr_be    = PMC_CSR_OFS[1] ? cfg_be[3:2] : cfg_be[1:0];
        // only the control/status halfword accepts data
        csr_wr_en = cfg_wr_req && hit_csr;
    end

    // ************************************************************
    // writable state
    // ************************************************************
    pmc_pstate_e state_q;
    logic        scratch_q;
    logic        change_q;
    logic [15:0] csr_wdata;

    // pick the halfword that carries control/status
    always_comb begin
        csr_wdata = PMC_CSR_OFS[1] ? cfg_wdata[31:16] : cfg_wdata[15:0];
    end

    // state field and scratch bit; a D3hot to D0 write resets nothing
    pmc_state_hold u_hold (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .wr_en     (csr_wr_en),
        .wr_be     (csr_be),
        .wr_data   (csr_wdata),
        .state_r   (state_q),
        .scratch_r (scratch_q),
        .change_r  (change_q)
    );

    // ************************************************************
    // read answer
    // ************************************************************
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        rdone_r;
    logic        rdone_nxt;
    logic        wdone_r;
    logic        wdone_nxt;
    logic [15:0] cap_now;
    logic [15:0] csr_now;

    // read data shows pre-write contents when read and write coincide
    always_comb begin
        cap_now   = cap_word(revision_select_bit);
        csr_now   = csr_word(revision_select_bit, scratch_q, state_q);
        rdata_nxt = 32'h0000_0000;
        rdone_nxt = cfg_rd_req;
        wdone_nxt = cfg_wr_req;
        if (cfg_rd_req && hit_cap) begin
            if (PMC_CAP_OFS[1]) begin
                rdata_nxt[31:16] = cap_now;
            end else begin
                rdata_nxt[15:0]  = cap_now;
            end
        end else if (cfg_rd_req && hit_csr) begin
            if (PMC_CSR_OFS[1]) begin
                rdata_nxt[31:16] = csr_now;
            end else begin
                rdata_nxt[15:0]  = csr_now;
            end
        end
    end

    // registered answer and done strobes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 32'h0000_0000;
            rdone_r <= 1'b0;
            wdone_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rdone_r <= rdone_nxt;
            wdone_r <= wdone_nxt;
        end
    end

    // ************************************************************
    // state outputs
    // ************************************************************
    logic        d3hot_r;
    logic        d3hot_nxt;

    // d3hot flag mirrors the held field
    always_comb begin
        d3hot_nxt = (state_q == PMC_D3HOT);
    end

    // one cycle later than the field itself
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            d3hot_r <= 1'b0;
        end else begin
            d3hot_r <= d3hot_nxt;
        end
    end

    // ************************************************************
    // output drive
    // ************************************************************
    // every output is a flip-flop of this block or of the holder
    always_comb begin
        cfg_rdata           = rdata_r;
        cfg_rdone           = rdone_r;
        cfg_wdone           = wdone_r;
        current_power_state = state_q;
        power_state_change  = change_q;
        in_d3hot            = d3hot_r;
    end

endmodule

`default_nettype wire

// >>> dv/pmc_regs_asserts.sv
// Purpose: port checker for pmc_regs
// Assumes: one clock domain, async active low reset
// Notes:   bound into the design below the module
`timescale 1ns/1ps
`default_nettype none
module pmc_regs_asserts
    import pmc_pkg::*;
#(
    parameter int CFG_AW = 8
)
(
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              rst_b,
    // configuration access
    input wire logic              cfg_rd_req,
    input wire logic              cfg_wr_req,
    input wire logic [CFG_AW-1:0] cfg_addr,
    input wire logic [3:0]        cfg_be,
    input wire logic [31:0]       cfg_wdata,
    input wire logic [31:0]       cfg_rdata,
    input wire logic              cfg_rdone,
    input wire logic              cfg_wdone,
    // revision and power state
    input wire logic              revision_select_bit,
    input wire logic [1:0]        current_power_state,
    input wire logic              power_state_change,
    input wire logic              in_d3hot
);
    // dword decode of the two registers
    logic at_cap;
    logic at_csr;
    logic st_wr;
    assign at_cap = cfg_addr[CFG_AW-1:2] == (CFG_AW-2)'(PMC_CAP_OFS >> 2);
    assign at_csr = cfg_addr[CFG_AW-1:2] == (CFG_AW-2)'(PMC_CSR_OFS >> 2);
    assign st_wr  = cfg_wr_req && at_csr && cfg_be[0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ****************
    // assertions
    // ****************
    property p_rd_ack; cfg_rd_req |=> cfg_rdone; endproperty
    a_rd_ack: assert property (p_rd_ack)
        else $error("read not answered");
    property p_wr_ack; cfg_wr_req |=> cfg_wdone; endproperty
    a_wr_ack: assert property (p_wr_ack)
        else $error("write not acknowledged");
    property p_cap; cfg_rd_req && at_cap |=>
        cfg_rdata == {13'h00C0, $past(revision_select_bit) ? 3'h3 : 3'h2, 16'h0000}; endproperty
    a_cap: assert property (p_cap)
        else $error("capability read wrong");
    property p_csr_fix; cfg_rd_req && at_csr |=>
        cfg_rdata[31:9] == 23'h0 && cfg_rdata[7:4] == 4'h0 && !cfg_rdata[2]; endproperty
    a_csr_fix: assert property (p_csr_fix)
        else $error("control status fixed bits wrong");
    property p_nsr; cfg_rd_req && at_csr |=> cfg_rdata[3] == $past(revision_select_bit);
    endproperty
    a_nsr: assert property (p_nsr)
        else $error("no soft reset flag wrong");
    property p_st_wr; st_wr |=> current_power_state == $past(cfg_wdata[1:0]); endproperty
    a_st_wr: assert property (p_st_wr)
        else $error("state not written");
    property p_st_hold; !st_wr |=> $stable(current_power_state); endproperty
    a_st_hold: assert property (p_st_hold)
        else $error("state moved without write");
    property p_change;
        power_state_change == (current_power_state != $past(current_power_state));
    endproperty
    a_change: assert property (p_change)
        else $error("change pulse wrong");
    property p_d3; in_d3hot == ($past(current_power_state) == 2'h3); endproperty
    a_d3: assert property (p_d3)
        else $error("d3hot level wrong");
    // main scenarios
    c_d3: cover property (in_d3hot);
    c_rw: cover property (cfg_rd_req && cfg_wr_req);
    c_new: cover property (cfg_rd_req && at_cap && revision_select_bit);
endmodule
bind pmc_regs pmc_regs_asserts #(.CFG_AW(CFG_AW)) chk_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .cfg_rd_req(cfg_rd_req), .cfg_wr_req(cfg_wr_req), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rdone(cfg_rdone),
    .cfg_wdone(cfg_wdone), .revision_select_bit(revision_select_bit),
    .current_power_state(current_power_state), .power_state_change(power_state_change),
    .in_d3hot(in_d3hot));
`default_nettype wire

// >>> dv/pmc_regs_bench.sv
// Purpose: self-checking bench for pmc_regs
// Assumes: inputs change on the falling edge
// Notes:   answers are looked at one falling edge after the request
`timescale 1ns/1ps
`default_nettype none
module pmc_regs_bench
    import pmc_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  be = 4'h0;
    logic [31:0] wd = 32'h0;
    logic        sel = 1'b0;
    logic [31:0] rdat;
    logic        rdone;
    logic        wdone;
    logic [1:0]  st;
    logic        chg;
    logic        d3;
    logic [1:0]  prev;
    int          error_cnt = 0;
    int          check_count = 0;
    int          cyc = 0;
    // ****************
    // design and clock
    // ****************
    pmc_regs #(.CFG_AW(8)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_rd_req(rd),
        .cfg_wr_req(wr), .cfg_addr(adr), .cfg_be(be), .cfg_wdata(wd), .cfg_rdata(rdat),
        .cfg_rdone(rdone), .cfg_wdone(wdone), .revision_select_bit(sel),
        .current_power_state(st), .power_state_change(chg), .in_d3hot(d3));
    always #2.5 clk_sys = ~clk_sys;
    // verdict and end of run
    task automatic summarize();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // compare a data word
    task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // compare a flag
    task automatic chk_flag(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    // one access, held over one rising edge
    task automatic xfer(input logic r, input logic w, input logic [7:0] a,
                        input logic [3:0] b, input logic [31:0] d);
        @(negedge clk_sys);
        rd = r;
        wr = w;
        adr = a;
        be = b;
        wd = d;
        @(negedge clk_sys);
        rd = 1'b0;
        wr = 1'b0;
        chk_flag("rdone", r, rdone);
        chk_flag("wdone", w, wdone);
    endtask
    // read and compare
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'b1, 1'b0, a, 4'h0, 32'h0);
        chk_data(nm, e, rdat);
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 1000) begin
            error_cnt++;
            summarize();
        end
    end
    // ****************
    // test sequence
    // ****************
    initial begin
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_b = 1'b1;
        rdchk(PMC_CAP_OFS, 32'h0602_0000, "cap_old");
        rdchk(PMC_CSR_OFS, 32'h0, "csr_rst");
        sel = 1'b1;
        rdchk(PMC_CAP_OFS, 32'h0603_0000, "cap_new");
        rdchk(PMC_CSR_OFS, 32'h0000_0008, "csr_new");
        xfer(1'b0, 1'b1, PMC_CAP_OFS, 4'hF, 32'hFFFF_FFFF);
        xfer(1'b0, 1'b1, PMC_CSR_OFS, 4'hC, 32'hFFFF_FFFF);
        rdchk(PMC_CAP_OFS, 32'h0603_0000, "cap_ro");
        rdchk(PMC_CSR_OFS, 32'h0000_0008, "csr_hi");
        xfer(1'b0, 1'b1, PMC_CSR_OFS, 4'hF, 32'hFFFF_FFFF);
        rdchk(PMC_CSR_OFS, 32'h0000_010B, "csr_ones");
        prev = 2'h3;
        // every state, a repeated one and a d3hot exit
        for (int i = 0; i < 6; i++) begin
            logic [1:0] s;
            s = (i == 0 || i == 4) ? 2'h3 : ((i == 5) ? 2'h0 : 2'(i - 1));
            xfer(1'b0, 1'b1, PMC_CSR_OFS, 4'h1, {30'h0, s});
            chk_data("state", {30'h0, s}, {30'h0, st});
            chk_flag("change", s != prev, chg);
            @(negedge clk_sys);
            chk_flag("d3hot", s == 2'h3, d3);
            prev = s;
        end
        rdchk(PMC_CSR_OFS, 32'h0000_0108, "csr_d0");
        xfer(1'b1, 1'b1, PMC_CSR_OFS, 4'h1, 32'h2);
        chk_data("rw_old", 32'h0000_0108, rdat);
        xfer(1'b0, 1'b1, PMC_CSR_OFS, 4'h2, 32'h0);
        rdchk(PMC_CSR_OFS, 32'h0000_000A, "csr_scr");
        sel = 1'b0;
        rdchk(PMC_CSR_OFS, 32'h0000_0002, "csr_old");
        rdchk(8'h60, 32'h0, "unmapped");
        xfer(1'b0, 1'b1, PMC_CSR_OFS, 4'h3, 32'h0101);
        @(negedge clk_sys);
        rst_b = 1'b0;
        @(negedge clk_sys);
        rst_b = 1'b1;
        chk_data("state_rst", 32'h0, {30'h0, st});
        rdchk(PMC_CSR_OFS, 32'h0, "csr_rst2");
        summarize();
    end
endmodule
`default_nettype wire
